// File: hw/psc_top.sv
// Sideband control of a pluggable module: select, reset, dual-role pins
`timescale 1ns/1ps
module psc_top
	import psc_pkg::*;
#(
	parameter int RESET_CYC = RESET_QUAL_CYC
) (
	input  wire logic              sys_clk,
	input  wire logic              rst_n,
	input  wire logic              link_clk,
	input  wire logic              module_select_n,
	input  wire logic              module_init_n,
	input  wire logic              lowpower_or_txoff_input,
	input  wire logic              twi_bus_busy,
	input  wire logic              mgmt_role_wr,
	input  wire logic              mgmt_role_txoff,
	input  wire logic              mgmt_role_los,
	input  wire logic              flag_rd_valid,
	input  wire logic [FLAG_W-1:0] flag_rd_mask,
	input  wire logic [FLAG_W-1:0] flag_evt,
	input  wire logic              rx_los,
	output logic                   twi_respond,
	output logic                   low_power_request,
	output logic                   transmit_disable,
	output logic                   module_present_n,
	output logic                   irq_or_loss_output,
	output logic                   irq_or_loss_output_oe,
	output logic                   module_init_busy,
	output logic                   input_role,
	output logic                   output_role,
	output logic      [FLAG_W-1:0] flags_o
);

	// ****************************************************
	// Elaboration checks
	// ****************************************************
	if (RESET_CYC < 2 || RESET_CYC > (2**CNT_W) - 1) begin : g_chk
		$error("RESET_CYC out of range for the qualifier counter");
	end

	localparam logic [CNT_W-1:0] QUAL_LAST = CNT_W'(RESET_CYC - 1);

	// ****************************************************
	// Declarations
	// ****************************************************
	psc_sys_t          sys_r;
	psc_sys_t          sys_nxt;
	psc_link_t         lnk_r;
	psc_link_t         lnk_nxt;
	logic              sel_n_s;
	logic              init_n_s;
	logic              lpt_s;
	logic              req_s;
	logic              ack_s;
	logic              take_cmd;
	logic [FLAG_W-1:0] flags;
	logic [FLAG_W-1:0] rd_clr;
	logic              lnk_idle;
	logic              launch;
	psc_cmd_t          new_evt;

	// ****************************************************
	// Pin synchronisers
	// ****************************************************
	// Idle value high: undriven pulled-up pins read high; select and reset inactive, low power asserted
	psc_sync #(.W(1), .RST_VAL(PIN_IDLE_VAL)) u_sync_sel (
		.clk   (link_clk),
		.rst_n (rst_n),
		.d     (module_select_n),
		.q     (sel_n_s)
	);

	psc_sync #(.W(1), .RST_VAL(PIN_IDLE_VAL)) u_sync_init (
		.clk   (sys_clk),
		.rst_n (rst_n),
		.d     (module_init_n),
		.q     (init_n_s)
	);

	psc_sync #(.W(1), .RST_VAL(PIN_IDLE_VAL)) u_sync_lpt (
		.clk   (sys_clk),
		.rst_n (rst_n),
		.d     (lowpower_or_txoff_input),
		.q     (lpt_s)
	);

	// ****************************************************
	// Handshake crossing
	// ****************************************************
	psc_sync #(.W(1), .RST_VAL(1'h0)) u_sync_req (
		.clk   (sys_clk),
		.rst_n (rst_n),
		.d     (lnk_r.req),
		.q     (req_s)
	);

	psc_sync #(.W(1), .RST_VAL(1'h0)) u_sync_ack (
		.clk   (link_clk),
		.rst_n (rst_n),
		.d     (sys_r.ack),
		.q     (ack_s)
	);

	// ****************************************************
	// Link domain: bus gating and command capture
	// ****************************************************
	always_comb begin
		lnk_nxt = lnk_r;
		new_evt = '0;
		lnk_idle = (lnk_r.req == ack_s);
		launch = lnk_idle && (lnk_r.pend != '0);
		// Select only moves while no transaction is running
		if (!twi_bus_busy) begin
			lnk_nxt.sel_applied = !sel_n_s;
		end
		lnk_nxt.respond = lnk_nxt.sel_applied;
		if (mgmt_role_wr) begin
			new_evt.role_valid = 1'h1;
			new_evt.txoff_role = mgmt_role_txoff;
			new_evt.los_role = mgmt_role_los;
		end
		if (flag_rd_valid) begin
			new_evt.rd_mask = flag_rd_mask;
		end
		// Hold is frozen until the ack comes back
		if (launch) begin
			lnk_nxt.hold = lnk_r.pend;
			lnk_nxt.req = !lnk_r.req;
			lnk_nxt.pend = new_evt;
		end else begin
			lnk_nxt.pend.rd_mask = lnk_r.pend.rd_mask | new_evt.rd_mask;
			if (new_evt.role_valid) begin
				lnk_nxt.pend.role_valid = 1'h1;
				lnk_nxt.pend.txoff_role = new_evt.txoff_role;
				lnk_nxt.pend.los_role = new_evt.los_role;
			end
		end
	end

	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			lnk_r <= '0;
		end else begin
			lnk_r <= lnk_nxt;
		end
	end

	// ****************************************************
	// Flags
	// ****************************************************
	assign take_cmd = (req_s != sys_r.ack);
	assign rd_clr = take_cmd ? lnk_r.hold.rd_mask : '0;

	psc_flag_bank #(.W(FLAG_W)) u_flags (
		.clk     (sys_clk),
		.rst_n   (rst_n),
		.set     (flag_evt),
		.clr     (rd_clr),
		.clr_all (sys_r.init_busy),
		.flags   (flags)
	);

	// ****************************************************
	// System domain: reset qualifier, roles, outputs
	// ****************************************************
	always_comb begin
		sys_nxt = sys_r;
		sys_nxt.present_n = PRESENT_VAL;
		sys_nxt.irq_val = OD_LOW_VAL;
		if (take_cmd) begin
			sys_nxt.ack = req_s;
		end
		case (sys_r.init_st)
			PSC_INIT_RUN: begin
				if (!init_n_s) begin
					sys_nxt.init_st = PSC_INIT_QUAL;
					sys_nxt.qual_cnt = CNT_W'(1);
				end
			end
			PSC_INIT_QUAL: begin
				// Short glitches never reset the settings
				if (init_n_s) begin
					sys_nxt.init_st = PSC_INIT_RUN;
					sys_nxt.qual_cnt = '0;
				end else if (sys_r.qual_cnt == QUAL_LAST) begin
					sys_nxt.init_st = PSC_INIT_HELD;
					sys_nxt.init_busy = 1'h1;
				end else begin
					sys_nxt.qual_cnt = sys_r.qual_cnt + CNT_W'(1);
				end
			end
			PSC_INIT_HELD: begin
				if (init_n_s) begin
					sys_nxt.init_st = PSC_INIT_RUN;
					sys_nxt.init_busy = 1'h0;
					sys_nxt.qual_cnt = '0;
				end
			end
			default: begin
				sys_nxt.init_st = PSC_INIT_RUN;
				sys_nxt.init_busy = 1'h0;
				sys_nxt.qual_cnt = '0;
			end
		endcase
		// Role writes are refused while a reset executes
		if (sys_nxt.init_busy || sys_r.init_busy) begin
			sys_nxt.in_role = IN_ROLE_LP;
			sys_nxt.out_role = OUT_ROLE_IRQ;
		end else if (take_cmd && lnk_r.hold.role_valid) begin
			sys_nxt.in_role = lnk_r.hold.txoff_role;
			sys_nxt.out_role = lnk_r.hold.los_role;
		end
		sys_nxt.lp_req = (sys_r.in_role == IN_ROLE_LP) && lpt_s;
		sys_nxt.tx_dis = (sys_r.in_role == IN_ROLE_TXOFF) && lpt_s;
		// Same idle level in both roles, so a quiet switch is silent
		if (sys_r.out_role == OUT_ROLE_IRQ) begin
			sys_nxt.irq_oe = |flags;
		end else begin
			sys_nxt.irq_oe = rx_los;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sys_r <= '{
				init_st:   PSC_INIT_RUN,
				qual_cnt:  '0,
				init_busy: 1'h0,
				in_role:   IN_ROLE_LP,
				out_role:  OUT_ROLE_IRQ,
				lp_req:    1'h0,
				tx_dis:    1'h0,
				irq_oe:    1'h0,
				irq_val:   OD_LOW_VAL,
				present_n: PRESENT_VAL,
				ack:       1'h0
			};
		end else begin
			sys_r <= sys_nxt;
		end
	end

	// ****************************************************
	// Outputs
	// ****************************************************
	assign twi_respond = lnk_r.respond;
	assign low_power_request = sys_r.lp_req;
	assign transmit_disable = sys_r.tx_dis;
	assign module_present_n = sys_r.present_n;
	assign irq_or_loss_output = sys_r.irq_val;
	assign irq_or_loss_output_oe = sys_r.irq_oe;
	assign module_init_busy = sys_r.init_busy;
	assign input_role = sys_r.in_role;
	assign output_role = sys_r.out_role;
	assign flags_o = flags;

	// ****************************************************
	// Assertions
	// ****************************************************
	logic [CNT_W-1:0] low_run_r;

	// Consecutive low samples of the synchronised reset pin
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			low_run_r <= '0;
		end else if (init_n_s) begin
			low_run_r <= '0;
		end else if (low_run_r != '1) begin
			low_run_r <= low_run_r + CNT_W'(1);
		end
	end

	default clocking cb_sys @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	AST_RESET_QUAL: assert property (
		(low_run_r >= CNT_W'(RESET_CYC)) |-> sys_r.init_busy)
		else $error("Qualified reset not executed");

	AST_RESET_GLITCH: assert property (
		sys_r.init_busy |-> (low_run_r >= CNT_W'(RESET_CYC)) || init_n_s)
		else $error("Reset executed on a short pulse");

	AST_INPUT_DEFAULT: assert property (
		sys_r.init_busy |=> sys_r.in_role == IN_ROLE_LP)
		else $error("Input role not low power after reset");

	AST_OUTPUT_DEFAULT: assert property (
		sys_r.init_busy |=> sys_r.out_role == OUT_ROLE_IRQ)
		else $error("Output role not interrupt after reset");

	AST_TXOFF_WRITE: assert property (
		(take_cmd && lnk_r.hold.role_valid && !sys_nxt.init_busy
		&& !sys_r.init_busy)
		|=> sys_r.in_role == $past(lnk_r.hold.txoff_role))
		else $error("Input role write not applied");

	AST_LOS_REFUSED: assert property (
		(sys_r.init_busy && take_cmd) |=> sys_r.out_role == OUT_ROLE_IRQ)
		else $error("Output role changed during reset");

	AST_LP_FOLLOW: assert property (
		(sys_r.in_role == IN_ROLE_LP && !lpt_s) |=> !sys_r.lp_req ##0
		!sys_r.tx_dis)
		else $error("Low power request wrong");

	AST_IRQ_ASSERT: assert property (
		(sys_r.out_role == OUT_ROLE_IRQ && flags != '0) |=> sys_r.irq_oe)
		else $error("Interrupt not driven with flag set");

	AST_IRQ_RELEASE: assert property (
		(sys_r.out_role == OUT_ROLE_IRQ && flags == '0) |=> !sys_r.irq_oe)
		else $error("Interrupt held with no flag set");

	AST_FLAG_SET_WINS: assert property (
		(flag_evt[FLAG_STATE] && !sys_r.init_busy)
		|=> flags[FLAG_STATE])
		else $error("Flag event lost");

	AST_QUIET_SWITCH: assert property (
		($changed(sys_r.out_role) && !sys_r.irq_oe && flags == '0
		&& !rx_los) |=> !sys_r.irq_oe)
		else $error("Quiet role switch moved the output");

	AST_OPEN_DRAIN: assert property (
		!sys_r.irq_val && !sys_r.present_n)
		else $error("Open collector or present level wrong");

	AST_GATE_OFF: assert property (
		@(posedge link_clk) disable iff (!rst_n)
		(sel_n_s && !twi_bus_busy) |=> !lnk_r.respond)
		else $error("Deselected module still responds");

	AST_GATE_ON: assert property (
		@(posedge link_clk) disable iff (!rst_n)
		(!sel_n_s && !twi_bus_busy) |=> lnk_r.respond)
		else $error("Selected module not responding");

	AST_IDLE_ONLY: assert property (
		@(posedge link_clk) disable iff (!rst_n)
		twi_bus_busy |=> $stable(lnk_r.sel_applied))
		else $error("Select moved mid transaction");

	COV_RESET_RUN: cover property (
		$rose(sys_r.init_busy) ##[1:300] !sys_r.init_busy);

	COV_ROLE_SWITCH: cover property (
		$rose(sys_r.out_role) ##[1:100] $rose(sys_r.in_role));

	COV_IRQ_CYCLE: cover property (
		$rose(sys_r.irq_oe) ##[1:300] $fell(sys_r.irq_oe));

	COV_SELECT: cover property (
		@(posedge link_clk) disable iff (!rst_n)
		$rose(lnk_r.respond) ##[1:100] $fell(lnk_r.respond));

endmodule

// File: hw/psc_pkg.sv
// Package for the pluggable module sideband control block
// Function
// - Selected module answers two-wire bus transactions
// - Deselected module neither responds nor acknowledges
// - Undriven select input reads as deselected
// - Qualified long reset restores all user defaults
// - Dual-role input active high, undriven asserted
// - After reset, input means low-power request
// - Bus write selects transmit-disable, not during reset
// - Present indicator held low while inserted
// - Dual-role output is active-low open collector
// - After reset, output is interrupt request
// - Any set flag pulls interrupt output low
// - Interrupt released only after all flags read
// - Bus write selects loss-of-signal role, not during reset
// - Role switch with no flags and no loss of signal leaves output unchanged
package psc_pkg;

	// ****************************************************
	// Sizes and counts
	// ****************************************************
	localparam int FLAG_W         = 3;
	localparam int FLAG_STATE     = 0;
	localparam int FLAG_FAULT     = 1;
	localparam int FLAG_CRIT      = 2;
	localparam int CNT_W          = 16;
	localparam int RESET_QUAL_CYC = 16;

	// ****************************************************
	// Role encodings and reset values
	// ****************************************************
	localparam logic IN_ROLE_LP    = 1'h0;
	localparam logic IN_ROLE_TXOFF = 1'h1;
	localparam logic OUT_ROLE_IRQ  = 1'h0;
	localparam logic OUT_ROLE_LOS  = 1'h1;
	localparam logic PIN_IDLE_VAL  = 1'h1;
	localparam logic PRESENT_VAL   = 1'h0;
	localparam logic OD_LOW_VAL    = 1'h0;

	// ****************************************************
	// Types
	// ****************************************************
	typedef enum logic [2:0] {
		PSC_INIT_RUN  = 3'h1,
		PSC_INIT_QUAL = 3'h2,
		PSC_INIT_HELD = 3'h4
	} psc_init_t;

	typedef struct packed {
		logic              role_valid;
		logic              txoff_role;
		logic              los_role;
		logic [FLAG_W-1:0] rd_mask;
	} psc_cmd_t;

	typedef struct packed {
		psc_init_t         init_st;
		logic [CNT_W-1:0]  qual_cnt;
		logic              init_busy;
		logic              in_role;
		logic              out_role;
		logic              lp_req;
		logic              tx_dis;
		logic              irq_oe;
		logic              irq_val;
		logic              present_n;
		logic              ack;
	} psc_sys_t;

	typedef struct packed {
		logic              sel_applied;
		logic              respond;
		logic              req;
		psc_cmd_t          pend;
		psc_cmd_t          hold;
	} psc_link_t;

endpackage

// File: hw/psc_sync.sv
// Two flip-flop synchroniser with a constant reset value
`timescale 1ns/1ps
module psc_sync
	import psc_pkg::*;
#(
	parameter int           W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [2*W-1:0] st_r;
	logic [2*W-1:0] st_nxt;

	// First stage feeds only the second stage
	always_comb begin
		st_nxt = {st_r[W-1:0], d};
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= {RST_VAL, RST_VAL};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign q = st_r[2*W-1:W];

endmodule

// File: hw/psc_flag_bank.sv
// Sticky interrupt flags, cleared per bit when read
`timescale 1ns/1ps
module psc_flag_bank
	import psc_pkg::*;
#(
	parameter int W = FLAG_W
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] set,
	input  wire logic [W-1:0] clr,
	input  wire logic         clr_all,
	output logic      [W-1:0] flags
);

	logic [W-1:0] flags_r;
	logic [W-1:0] flags_nxt;

	// Set beats read-clear so no event is lost; reset beats both
	always_comb begin
		if (clr_all) begin
			flags_nxt = '0;
		end else begin
			flags_nxt = set | (flags_r & ~clr);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flags_r <= '0;
		end else begin
			flags_r <= flags_nxt;
		end
	end

	assign flags = flags_r;

endmodule

// File: tb/psc_host_model.sv
// Host board model: select pin, bus activity, management writes and reads
`timescale 1ns/1ps
module psc_host_model
	import psc_pkg::*;
(
	input  wire logic              link_clk,
	output logic                   module_select_n,
	output logic                   twi_bus_busy,
	output logic                   mgmt_role_wr,
	output logic                   mgmt_role_txoff,
	output logic                   mgmt_role_los,
	output logic                   flag_rd_valid,
	output logic      [FLAG_W-1:0] flag_rd_mask
);
	// Select waits longer than the three link edges the gate needs
	localparam int SEL_WAIT = 6;
	localparam int HS_GAP   = 8;

	// ****************************************************
	// Idle levels
	// ****************************************************
	initial begin
		module_select_n = PIN_IDLE_VAL;
		twi_bus_busy    = 1'b0;
		mgmt_role_wr    = 1'b0;
		mgmt_role_txoff = 1'b0;
		mgmt_role_los   = 1'b0;
		flag_rd_valid   = 1'b0;
		flag_rd_mask    = '0;
	end

	// ****************************************************
	// Host operations, all launched after a falling link edge
	// ****************************************************
	task automatic select(input logic s);
		@(negedge link_clk);
		module_select_n = ~s;
		repeat (SEL_WAIT) @(negedge link_clk);
	endtask

	task automatic bus_busy(input logic b);
		@(negedge link_clk);
		twi_bus_busy = b;
	endtask

	task automatic role_write(input logic tx, input logic los);
		@(negedge link_clk);
		mgmt_role_wr    = 1'b1;
		mgmt_role_txoff = tx;
		mgmt_role_los   = los;
		@(negedge link_clk);
		mgmt_role_wr    = 1'b0;
		// Qualifiers scrambled once the write is gone
		mgmt_role_txoff = ~tx;
		mgmt_role_los   = ~los;
		repeat (HS_GAP) @(negedge link_clk);
	endtask

	task automatic read_flags(input logic [FLAG_W-1:0] m);
		@(negedge link_clk);
		flag_rd_valid = 1'b1;
		flag_rd_mask  = m;
		@(negedge link_clk);
		flag_rd_valid = 1'b0;
		flag_rd_mask  = ~m;
		repeat (HS_GAP) @(negedge link_clk);
	endtask
endmodule

// File: tb/tb_pluggable_module_sideband_control.sv
// Self-checking bench of the sideband control block
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_fail++; \
	$display("[FAIL] %0t line %0d got %h exp %h", $time, `__LINE__, \
	(a), (e)); end end
`define WAITC(c) for (int w = 0; w < 200 && !(c); w++) @(negedge sys_clk); \
	if (!(c)) begin n_fail++; $display("[FAIL] %0t wait timed out", \
	$time); end
module tb_pluggable_module_sideband_control;
	import psc_pkg::*;
	// Short qualification count keeps the run brief
	localparam int RCYC = 4;
	logic              sys_clk, link_clk, rst_n, module_init_n;
	logic              lp_pin, rx_los, sel_n, bus_busy, rwr, rtx, rlos;
	logic              frv, twi_respond, low_power_request;
	logic              transmit_disable, module_present_n, irq_o, irq_oe;
	logic              init_busy, input_role, output_role;
	logic [FLAG_W-1:0] frm, flag_evt, flags_o, exp_flags, m;
	logic              exp_in, exp_out;
	integer            seed;
	int                n_fail, tests_run;
	// Host pull-up resolves the open-drain pin
	wire logic         irq_pin = irq_oe ? irq_o : 1'b1;

	psc_top #(.RESET_CYC(RCYC)) psc_top_inst (
		.sys_clk(sys_clk), .rst_n(rst_n), .link_clk(link_clk),
		.module_select_n(sel_n), .module_init_n(module_init_n),
		.lowpower_or_txoff_input(lp_pin), .twi_bus_busy(bus_busy),
		.mgmt_role_wr(rwr), .mgmt_role_txoff(rtx), .mgmt_role_los(rlos),
		.flag_rd_valid(frv), .flag_rd_mask(frm), .flag_evt(flag_evt),
		.rx_los(rx_los), .twi_respond(twi_respond),
		.low_power_request(low_power_request),
		.transmit_disable(transmit_disable),
		.module_present_n(module_present_n), .irq_or_loss_output(irq_o),
		.irq_or_loss_output_oe(irq_oe), .module_init_busy(init_busy),
		.input_role(input_role), .output_role(output_role),
		.flags_o(flags_o));

	psc_host_model psc_host_model_inst (
		.link_clk(link_clk), .module_select_n(sel_n),
		.twi_bus_busy(bus_busy), .mgmt_role_wr(rwr),
		.mgmt_role_txoff(rtx), .mgmt_role_los(rlos),
		.flag_rd_valid(frv), .flag_rd_mask(frm));

	// ****************************************************
	// Clocks, expectations and reporting
	// ****************************************************
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	initial begin
		link_clk = 1'b0;
		#7;
		forever #32 link_clk = ~link_clk;
	end

	function automatic logic irq_exp();
		return (exp_out == OUT_ROLE_IRQ) ? |exp_flags : rx_los;
	endfunction

	task automatic final_report();
		if (n_fail == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic settle();
		repeat (4) @(negedge sys_clk);
	endtask

	task automatic check_all();
		`CHK(input_role, exp_in)
		`CHK(output_role, exp_out)
		`CHK(flags_o, exp_flags)
		`CHK(low_power_request, (exp_in == IN_ROLE_LP) & lp_pin)
		`CHK(transmit_disable, (exp_in == IN_ROLE_TXOFF) & lp_pin)
		`CHK(irq_pin, ~irq_exp())
		`CHK(irq_o, OD_LOW_VAL)
		`CHK(module_present_n, PRESENT_VAL)
	endtask

	task automatic role_wr(input logic tx, input logic los);
		psc_host_model_inst.role_write(tx, los);
		`WAITC(input_role === exp_in && output_role === exp_out);
		settle();
	endtask

	initial begin
		#2000000;
		n_fail++;
		final_report();
	end

	// ****************************************************
	// Main sequence
	// ****************************************************
	initial begin
		seed = 32'h0A7D97B8;
		n_fail = 0;
		tests_run = 0;
		rst_n = 1'b0;
		module_init_n = 1'b1;
		lp_pin = 1'b1;
		rx_los = 1'b0;
		flag_evt = '0;
		exp_in = IN_ROLE_LP;
		exp_out = OUT_ROLE_IRQ;
		exp_flags = '0;
		repeat (12) @(negedge sys_clk);
		rst_n = 1'b1;
		settle();
		check_all();
		`CHK(twi_respond, 1'b0)
		// Random flag events against random partial reads
		for (int i = 0; i < 10; i++) begin
			lp_pin = 1'($random(seed));
			flag_evt = FLAG_W'($random(seed));
			exp_flags = exp_flags | flag_evt;
			@(negedge sys_clk);
			flag_evt = '0;
			settle();
			check_all();
			m = FLAG_W'($random(seed));
			psc_host_model_inst.read_flags(m);
			exp_flags = exp_flags & ~m;
			`WAITC(flags_o === exp_flags);
			settle();
			check_all();
		end
		psc_host_model_inst.read_flags({FLAG_W{1'b1}});
		exp_flags = '0;
		`WAITC(flags_o === exp_flags);
		settle();
		check_all();
		// Select gating and deselect held off by a running transfer
		psc_host_model_inst.select(1'b1);
		`CHK(twi_respond, 1'b1)
		psc_host_model_inst.bus_busy(1'b1);
		psc_host_model_inst.select(1'b0);
		`CHK(twi_respond, 1'b1)
		psc_host_model_inst.bus_busy(1'b0);
		repeat (12) @(negedge sys_clk);
		`CHK(twi_respond, 1'b0)
		// Every role pair; a switch with no flag keeps the pin high
		for (int i = 0; i < 4; i++) begin
			rx_los = 1'b0;
			exp_in = i[0];
			exp_out = i[1];
			role_wr(exp_in, exp_out);
			check_all();
			rx_los = 1'($random(seed));
			lp_pin = ~lp_pin;
			settle();
			check_all();
		end
		rx_los = 1'b0;
		// Short module reset pulse is not qualified
		module_init_n = 1'b0;
		@(negedge sys_clk);
		module_init_n = 1'b1;
		repeat (RCYC + 6) begin
			@(negedge sys_clk);
			`CHK(init_busy, 1'b0)
		end
		// Long pulse restores defaults and blocks role writes
		flag_evt = 3'h5;
		@(negedge sys_clk);
		flag_evt = '0;
		module_init_n = 1'b0;
		`WAITC(init_busy === 1'b1);
		`CHK(init_busy, 1'b1)
		exp_in = IN_ROLE_LP;
		exp_out = OUT_ROLE_IRQ;
		exp_flags = '0;
		psc_host_model_inst.role_write(1'b1, 1'b1);
		settle();
		check_all();
		module_init_n = 1'b1;
		`WAITC(init_busy === 1'b0);
		settle();
		check_all();
		final_report();
	end
endmodule
